// file: shared/wwdt_pkg.sv
/*
 * shared constants of the window watchdog: timing figures, register map,
 * status bit positions and the state encoding.
 * assumes a 125 MHz system clock and a plain strobe register port.
 */
package wwdt_pkg;
    // clock rate, used to turn microseconds into cycles
    localparam int CLK_MHZ        = 125;
    // window figures in microseconds, per pin configuration
    localparam int T_LO_00_US     = 25900;    // lower bound, selects low/low
    localparam int T_UP_00_US     = 46800;    // upper bound, selects low/low
    localparam int T_LO_11_US     = 800000;   // lower bound, selects high/high
    localparam int T_UP_11_US     = 1600000;  // upper bound, selects high/high
    localparam int T_LO_MIX_US    = 100000;   // lower bound, mixed selects
    localparam int T_UP_MIX_US    = 200000;   // upper bound, mixed selects
    localparam int T_HOLD_US      = 200000;   // fault output hold time
    // worst-case bounds of the high/high window; the typical figures must sit inside them
    localparam int T_LO_11_MAX_US = 920000;   // lower bound never later than this
    localparam int T_UP_11_MIN_US = 1360000;  // upper bound never earlier than this
    // derived cycle counts; all figures are whole cycles already
    localparam int LO_00_CYC      = T_LO_00_US * CLK_MHZ;
    localparam int UP_00_CYC      = T_UP_00_US * CLK_MHZ;
    localparam int LO_11_CYC      = T_LO_11_US * CLK_MHZ;
    localparam int UP_11_CYC      = T_UP_11_US * CLK_MHZ;
    localparam int LO_MIX_CYC     = T_LO_MIX_US * CLK_MHZ;
    localparam int UP_MIX_CYC     = T_UP_MIX_US * CLK_MHZ;
    localparam int HOLD_CYC       = T_HOLD_US * CLK_MHZ;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_SWLO   = 8'h04;
    localparam logic [7:0] ADDR_SWUP   = 8'h08;
    localparam logic [7:0] ADDR_STAT   = 8'h0C;
    localparam logic [7:0] ADDR_MASK   = 8'h10;
    localparam logic [7:0] ADDR_STATE  = 8'h14;
    // reset values
    localparam logic [31:0] SWLO_RST   = 32'h0000_1000;
    localparam logic [31:0] SWUP_RST   = 32'h0000_2000;
    localparam logic        CTRL_RST   = 1'b1;
    localparam logic [2:0]  MASK_RST   = 3'h0;
    // status bit positions
    localparam int ST_EARLY       = 0;
    localparam int ST_LATE        = 1;
    localparam int ST_RELEASE     = 2;
    localparam int NUM_EV         = 3;
    // window states, gray along start -> open -> fault -> latch
    typedef enum logic [1:0] {
        WS_START = 2'h0,
        WS_OPEN  = 2'h1,
        WS_FAULT = 2'h3,
        WS_LATCH = 2'h2
    } wwdt_state_t;
endpackage : wwdt_pkg

// file: tb/window_watchdog_timer_tb.sv
/*
 * self-checking bench of the window watchdog core with short windows.
 * assumes the core parameters scale every window and hold time.
 */
`timescale 1ns/10ps
module window_watchdog_timer_tb;
    import wwdt_pkg::*;
    localparam int HOLD = 16;
    typedef struct packed {logic hi; logic lo; logic fault; logic [6:0] gap;} wwdt_row_t;
    logic sys_clk = 1'b0, reset = 1'b1, kick_req = 1'b0, sel_lo = 1'b0, sel_hi = 1'b0, latch_mode = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, irq, kick_pin, oe, drv;
    logic clk_en = 1'b1, timing_pin = 1'b0;
    int errors = 0, checks_done = 0, n;
    wwdt_row_t rows [6];
    // open-drain pin with pull-up; the latch feedback buffer ties it to the delay pin
    wire fault_pin = oe ? drv : 1'b1;
    wire rdly_pin  = latch_mode ? fault_pin : 1'b1;

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    wwdt_host u_wwdt_host (.sys_clk(sys_clk), .reset(reset), .kick_req(kick_req), .kick_pulse_input(kick_pin));
    wwdt_core #(.LO_00(20), .UP_00(40), .LO_11(30), .UP_11(60), .LO_MIX(25), .UP_MIX(50), .HOLD(HOLD)) u_wwdt_core (
        .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .kick_pulse_input(kick_pin),
        .window_select_lo(sel_lo), .window_select_hi(sel_hi), .window_timing_pin(timing_pin),
        .reset_delay_pin(rdly_pin), .fault_output_n_i(fault_pin), .fault_output_n_o(drv),
        .fault_output_n_oe(oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // selects are settled before reset lets the window start
    task automatic restart(input logic hi, input logic lo, input logic lat);
        @(posedge sys_clk);
        reset <= 1'b1; sel_hi <= hi; sel_lo <= lo; latch_mode <= lat;
        tick(3);
        reset <= 1'b0;
    endtask : restart
    task automatic kick;
        @(posedge sys_clk) kick_req <= 1'b1;
        @(posedge sys_clk) kick_req <= 1'b0;
    endtask : kick
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= wr; reg_rd <= ~wr;
        @(posedge sys_clk);
        reg_wr <= 1'b0; reg_rd <= 1'b0;
        #1;
        if (!wr) chk(reg_rdata, d, "read data");
    endtask : reg_op
    // bounded wait for the fault drive; an exhausted bound ends the run
    task automatic wait_oe(input int lim);
        n = 0;
        while (oe !== 1'b1) begin
            tick(1); n++;
            if (n > lim) begin
                errors++; $display("BAD %0t fault never driven", $time); give_verdict();
            end
        end
    endtask : wait_oe

    initial begin
        rows[0] = '{1'b0, 1'b0, 1'b0, 7'd30}; rows[1] = '{1'b0, 1'b0, 1'b1, 7'd8};
        rows[2] = '{1'b1, 1'b1, 1'b0, 7'd45}; rows[3] = '{1'b1, 1'b1, 1'b1, 7'd12};
        rows[4] = '{1'b0, 1'b1, 1'b0, 7'd37}; rows[5] = '{1'b1, 1'b0, 1'b1, 7'd10};
        tick(3);
        reset <= 1'b0;
        tick(1);
        chk(oe, 1'b0, "idle after reset");
        // window per select setting: early kick faults, in-window kick twice
        foreach (rows[i]) begin
            restart(rows[i].hi, rows[i].lo, 1'b0);
            tick(rows[i].gap); kick(); tick(6);
            chk(oe, rows[i].fault, "window row");
            if (!rows[i].fault) begin
                tick(rows[i].gap - 8); kick(); tick(6);
                chk(oe, 1'b0, "window restart on kick");
            end
            $display("row %0d done", i);
        end
        // missing kick: late fault, then exact hold and release
        restart(1'b0, 1'b0, 1'b0);
        wait_oe(60);
        chk(n >= 38 && n <= 46, 1'b1, "late fault moment");
        chk(fault_pin, 1'b0, "pin pulled low");
        n = 0;
        while (oe === 1'b1 && n < 40) begin tick(1); n++; end
        chk(n, HOLD, "hold length");
        wait_oe(60);
        chk(n >= 38 && n <= 46, 1'b1, "window restart after release");
        $display("late test done");
        // latched fault through the feedback buffer
        restart(1'b0, 1'b0, 1'b1);
        wait_oe(60);
        tick(3 * HOLD);
        chk(oe, 1'b1, "latched fault");
        reg_op(1'b0, ADDR_STATE, {30'h0, WS_LATCH});
        $display("latch test done");
        // clock enable low freezes the window; it resumes from where it stood
        restart(1'b0, 1'b0, 1'b0);
        clk_en <= 1'b0;
        tick(60);
        chk(oe, 1'b0, "window frozen by clock enable");
        clk_en <= 1'b1;
        wait_oe(60);
        chk(n >= 38 && n <= 46, 1'b1, "late fault after freeze");
        $display("enable test done");
        // software window: timing pin high, bounds from the registers
        timing_pin <= 1'b1;
        restart(1'b0, 1'b0, 1'b0);
        reg_op(1'b1, ADDR_SWLO, 32'h0000_000A);
        reg_op(1'b1, ADDR_SWUP, 32'h0000_001E);
        tick(12); kick(); tick(6);
        chk(oe, 1'b0, "kick inside software window");
        wait_oe(40);
        chk(n >= 25 && n <= 29, 1'b1, "software window late fault");
        timing_pin <= 1'b0;
        $display("software window test done");
        // interrupt and register table
        restart(1'b0, 1'b0, 1'b0);
        reg_op(1'b1, ADDR_MASK, 32'h7);
        tick(2); kick(); tick(6);
        chk(irq, 1'b1, "irq on early fault");
        reg_op(1'b0, ADDR_STAT, 32'h1);
        tick(1);
        chk(irq, 1'b0, "irq cleared by read");
        reg_op(1'b0, ADDR_CTRL, 32'h1);
        reg_op(1'b0, ADDR_SWLO, SWLO_RST);
        reg_op(1'b0, ADDR_SWUP, SWUP_RST);
        reg_op(1'b0, ADDR_MASK, 32'h7);
        reg_op(1'b0, 8'h18, 32'h0);
        $display("register test done");
        give_verdict();
    end
endmodule : window_watchdog_timer_tb

// file: tb/wwdt_host.sv
/*
 * host-side model: drives the kick pin with one falling edge per request.
 * assumes the bench asks for kicks on sys_clk and spaces them itself.
 */
`timescale 1ns/10ps
module wwdt_host (
    input  wire logic sys_clk,         // 125 MHz clock
    input  wire logic reset,           // sync reset, active high
    input  wire logic kick_req,        // one-cycle request for a kick
    output logic      kick_pulse_input // push-pull kick pin, idle high
);
    logic [1:0] low_q; // cycles the pin stays low

    // pin held low four cycles so the two-flop sync cannot miss it;
    // the bench spaces requests inside the window
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            kick_pulse_input <= 1'b1;
            low_q            <= 2'h0;
        end else if (kick_req) begin
            kick_pulse_input <= 1'b0;
            low_q            <= 2'h3;
        end else if (low_q != 2'h0) begin
            low_q <= low_q - 2'h1;
        end else begin
            kick_pulse_input <= 1'b1;
        end
    end
endmodule : wwdt_host

// file: verilog/wwdt_core.sv
/*
 * window watchdog core: checks host kick edges against a lower and upper
 * window bound, drives the open-drain fault output, holds or latches it,
 * and offers a small register file with a sticky-status interrupt.
 * assumes kick, select, timing, feedback and fault-pin inputs are
 * asynchronous pins; the register port is on sys_clk.
 */
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
//Contract
//- window chosen from timing pin plus both window select pins
//- timing pin open, selects low: lower at most 25.9 ms, upper 46.8 ms
//- timing pin open, selects high: typical window 800 ms to 1.6 s
//- selects high: lower at most 920 ms, upper at least 1360 ms
//- no kick before upper bound drives fault output low
//- feedback low on reset delay pin latches fault until restart
//- kick before lower bound or after upper bound is a fault
//- reset delay pin open: hold fault 200 ms, then release
module wwdt_core import wwdt_pkg::*; #(
    parameter int LO_00   = LO_00_CYC,   // lower bound, selects low/low
    parameter int UP_00   = UP_00_CYC,   // upper bound, selects low/low
    parameter int LO_11   = LO_11_CYC,   // lower bound, selects high/high
    parameter int UP_11   = UP_11_CYC,   // upper bound, selects high/high
    parameter int LO_MIX  = LO_MIX_CYC,  // lower bound, mixed selects
    parameter int UP_MIX  = UP_MIX_CYC,  // upper bound, mixed selects
    parameter int HOLD    = HOLD_CYC     // fault hold time
) (
    input  wire logic        sys_clk,           // 125 MHz clock
    input  wire logic        reset,             // sync reset, active high
    input  wire logic        clk_en,            // freezes all state when low
    input  wire logic        kick_pulse_input,  // host kick pin
    input  wire logic        window_select_lo,  // window select pin 0
    input  wire logic        window_select_hi,  // window select pin 1
    input  wire logic        window_timing_pin, // high: software window
    input  wire logic        reset_delay_pin,   // low: fault fed back, latch
    input  wire logic        fault_output_n_i,  // fault pin level seen
    output logic             fault_output_n_o,  // fault pin drive value
    output logic             fault_output_n_oe, // fault pin pulled low
    input  wire logic [7:0]  reg_addr,          // register byte address
    input  wire logic [31:0] reg_wdata,         // write data
    input  wire logic        reg_wr,            // write strobe
    input  wire logic        reg_rd,            // read strobe
    output logic      [31:0] reg_rdata,         // read data, next cycle
    output logic             irq                // level interrupt
);
    // pin synchronisers: stage one is read only by stage two
    logic [5:0] sync1_q, sync2_q;
    logic       kick_prev_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sync1_q     <= 6'h3F;
            sync2_q     <= 6'h3F;
            kick_prev_q <= 1'b1;
        end else if (clk_en) begin
            sync1_q     <= {fault_output_n_i, reset_delay_pin, window_timing_pin,
                            window_select_hi, window_select_lo, kick_pulse_input};
            sync2_q     <= sync1_q;
            kick_prev_q <= sync2_q[0];
        end
    end

    wire       kick_fall  = kick_prev_q & ~sync2_q[0];
    wire [1:0] sel        = sync2_q[2:1];
    wire       timing_sw  = sync2_q[3];
    wire       feedback_n = sync2_q[4];
    wire       pin_level  = sync2_q[5];

    // registers
    logic              en_q;
    logic [31:0]       swlo_q, swup_q;
    logic [NUM_EV-1:0] stat_q, mask_q;
    wwdt_state_t       state_q, state_d;
    logic [31:0]       cnt_q, cnt_d;

    // window limit selection; a zero software bound makes that edge match only at counter value 32'hFFFFFFFF
    wire [31:0] pin_lo = (sel == 2'b00) ? LO_00[31:0] :
                         (sel == 2'b11) ? LO_11[31:0] : LO_MIX[31:0];
    wire [31:0] pin_up = (sel == 2'b00) ? UP_00[31:0] :
                         (sel == 2'b11) ? UP_11[31:0] : UP_MIX[31:0];
    wire [31:0] lo_lim = timing_sw ? swlo_q : pin_lo;
    wire [31:0] up_lim = timing_sw ? swup_q : pin_up;
    wire        lo_hit = (cnt_q == lo_lim - 32'h1);
    wire        up_hit = (cnt_q == up_lim - 32'h1);
    wire        hold_hit = (cnt_q == HOLD[31:0] - 32'h1);

    // events of this cycle
    wire ev_early   = en_q && (state_q == WS_START) && kick_fall;
    wire ev_late    = en_q && (state_q == WS_OPEN) && up_hit && !kick_fall;
    wire ev_release = (state_q == WS_FAULT) && hold_hit && feedback_n;

    // window state machine; kicks while faulted are ignored
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 32'h1;
        case (state_q)
            WS_START: begin
                if (!en_q) begin
                    cnt_d = 32'h0;
                end else if (ev_early) begin
                    state_d = WS_FAULT;
                    cnt_d   = 32'h0;
                end else if (lo_hit) begin
                    state_d = WS_OPEN;
                end
            end
            WS_OPEN: begin
                if (!en_q) begin
                    state_d = WS_START;
                    cnt_d   = 32'h0;
                end else if (kick_fall) begin
                    state_d = WS_START;
                    cnt_d   = 32'h0;
                end else if (ev_late) begin
                    state_d = WS_FAULT;
                    cnt_d   = 32'h0;
                end
            end
            WS_FAULT: begin
                if (!feedback_n) begin
                    state_d = WS_LATCH;
                end else if (ev_release) begin
                    state_d = WS_START;
                    cnt_d   = 32'h0;
                end
            end
            WS_LATCH: begin
                cnt_d = cnt_q;
            end
            default: begin
                state_d = WS_START;
                cnt_d   = 32'h0;
            end
        endcase
    end

    wire fault_d = (state_d == WS_FAULT) || (state_d == WS_LATCH);

    // state, counter and pin drive; only a reset leaves the latch
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q           <= WS_START;
            cnt_q             <= 32'h0;
            fault_output_n_oe <= 1'b0;
        end else if (clk_en) begin
            state_q           <= state_d;
            cnt_q             <= cnt_d;
            fault_output_n_oe <= fault_d;
        end
    end

    // open drain: the driven value is always low
    always_ff @(posedge sys_clk) begin
        fault_output_n_o <= 1'b0;
    end

    // register decode
    wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    wire wr_swlo = reg_wr && (reg_addr == ADDR_SWLO);
    wire wr_swup = reg_wr && (reg_addr == ADDR_SWUP);
    wire wr_mask = reg_wr && (reg_addr == ADDR_MASK);
    wire rd_stat = reg_rd && (reg_addr == ADDR_STAT);
    wire [NUM_EV-1:0] ev_vec = {ev_release, ev_late, ev_early};
    // set wins over the read-clear so an event in the read cycle survives
    wire [NUM_EV-1:0] stat_d = (rd_stat ? {NUM_EV{1'b0}} : stat_q) | ev_vec;
    wire [31:0] rd_mux =
        (reg_addr == ADDR_CTRL)  ? {31'h0, en_q} :
        (reg_addr == ADDR_SWLO)  ? swlo_q :
        (reg_addr == ADDR_SWUP)  ? swup_q :
        (reg_addr == ADDR_STAT)  ? {29'h0, stat_q} :
        (reg_addr == ADDR_MASK)  ? {29'h0, mask_q} :
        (reg_addr == ADDR_STATE) ? {26'h0, pin_level, timing_sw, sel, state_q} : 32'h0; // fields side by side

    // register file, status and interrupt
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            en_q      <= CTRL_RST;
            swlo_q    <= SWLO_RST;
            swup_q    <= SWUP_RST;
            mask_q    <= MASK_RST;
            stat_q    <= '0;
            reg_rdata <= 32'h0;
            irq       <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl) en_q   <= reg_wdata[0];
            if (wr_swlo) swlo_q <= reg_wdata;
            if (wr_swup) swup_q <= reg_wdata;
            if (wr_mask) mask_q <= reg_wdata[NUM_EV-1:0];
            stat_q    <= stat_d;
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
            irq       <= |(stat_d & (wr_mask ? reg_wdata[NUM_EV-1:0] : mask_q));
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset || !clk_en);

    win_pick_a: assert property (state_q == WS_OPEN |-> cnt_q >= lo_lim)
        else $error("window opened before lower bound");
    cfg_low_a: assert property (!timing_sw && sel == 2'b00 |-> lo_lim <= LO_00[31:0] && up_lim >= UP_00[31:0])
        else $error("low select window out of range");
    cfg_typ_a: assert property (!timing_sw && sel == 2'b11 |-> lo_lim == LO_11[31:0] && up_lim == UP_11[31:0])
        else $error("high select window not typical");
    // scaled against the parameters so a shortened window is judged by the same ratio
    cfg_bound_a: assert property (!timing_sw && sel == 2'b11 |->
            longint'(lo_lim) * T_LO_11_US <= longint'(LO_11) * T_LO_11_MAX_US &&
            longint'(up_lim) * T_UP_11_US >= longint'(UP_11) * T_UP_11_MIN_US)
        else $error("high select window out of bounds");
    late_fault_a: assert property (ev_late |=> fault_output_n_oe && state_q == WS_FAULT)
        else $error("missing kick did not fault");
    latch_hold_a: assert property (state_q == WS_LATCH |=> state_q == WS_LATCH && fault_output_n_oe)
        else $error("latched fault released");
    early_fault_a: assert property (state_q == WS_START && en_q && kick_fall |=> fault_output_n_oe)
        else $error("early kick did not fault");
    hold_time_a: assert property ($fell(fault_output_n_oe) |-> $past(cnt_q) == HOLD[31:0] - 32'h1)
        else $error("fault released at wrong time");
    restart_a: assert property (state_q == WS_OPEN && kick_fall |=> cnt_q == 32'h0 && state_q == WS_START)
        else $error("kick did not restart window");
    irq_level_a: assert property (|(stat_q & mask_q) && !reg_rd |-> irq)
        else $error("interrupt missing");

    good_kick_c: cover property (state_q == WS_OPEN && kick_fall);
    early_kick_c: cover property (ev_early);
    release_c: cover property (ev_release);
    latch_c: cover property (state_q == WS_LATCH);
endmodule : wwdt_core
